/* File: rtl/lcdw_pkg.sv */
// Package: constants, register map and carrier types of the LCD drive control block
package lcdw_pkg;

	// Sizes
	localparam int COM_N = 8;
	localparam int SEG_N = 16;
	localparam int LVL_W = 3;

	// Register byte offsets
	localparam logic [7:0] ADR_MAIN = 8'h00;
	localparam logic [7:0] ADR_AUX  = 8'h04;
	localparam logic [7:0] ADR_STAT = 8'h08;
	localparam logic [2:0] ADR_SEG_HI = 3'h2;   // Pattern words at 0x40..0x5c

	// Field positions, control register
	localparam int MAIN_EN_BIT   = 0;
	localparam int MAIN_IS_LSB   = 1;
	localparam int MAIN_SRC_LSB  = 4;
	localparam int MAIN_KIND_BIT = 6;
	localparam int MAIN_TYPE_BIT = 7;
	// Field positions, duty register
	localparam int AUX_QUART_BIT = 0;
	localparam int AUX_DUTY_LSB  = 1;
	// Field positions, status register
	localparam int ST_RESET_BIT = 0;
	localparam int ST_FLOAT_BIT = 1;
	localparam int ST_PUMP_BIT  = 2;
	localparam int ST_PHASE_LSB = 4;
	localparam int ST_POL_BIT   = 7;

	// Reset values and writable masks
	localparam logic [7:0] MAIN_RST  = 8'h00;
	localparam logic [7:0] AUX_RST   = 8'h00;
	localparam logic [7:0] MAIN_MASK = 8'hf7;
	localparam logic [7:0] AUX_MASK  = 8'h07;

	// Duty and capacitor source encodings
	localparam logic [1:0] DUTY_QUARTER = 2'h0;
	localparam logic [1:0] DUTY_SIXTH   = 2'h1;
	localparam logic [1:0] DUTY_EIGHTH  = 2'h2;
	localparam logic [1:0] SRC_EXT_PIN  = 2'h0;
	localparam logic [1:0] SRC_DEPL_REF = 2'h1;
	localparam logic [1:0] SRC_FIXED_3V = 2'h2;
	localparam logic [1:0] SRC_CORE     = 2'h3;

	// Drive level codes, in bias steps above ground
	localparam logic [2:0] LVL_VSS  = 3'h0;
	localparam logic [2:0] LVL_ONE  = 3'h1;
	localparam logic [2:0] LVL_TWO  = 3'h2;
	localparam logic [2:0] LVL_TOP3 = 3'h3;
	localparam logic [2:0] LVL_TOP4 = 3'h4;

	// Timing
	localparam int unsigned REF_CLK_MHZ = 125;
	localparam int unsigned LCD_SRC_HZ  = 32768;
	localparam int unsigned TICK_CYC    = (REF_CLK_MHZ * 1000000) / LCD_SRC_HZ;
	localparam logic [2:0]  DIV_LAST    = 3'h7;  // Eight LCD ticks per division

	// Pin drive: enable plus level code
	typedef struct packed {
		logic             oe;
		logic [LVL_W-1:0] level;
	} lcdw_pin_t;

	// System state levels arriving from the chip
	typedef struct packed {
		logic sleep;
		logic idle;
		logic mcu_rst;
		logic wdt_rst;
	} lcdw_sys_t;

	typedef enum logic [1:0] {
		BUS_IDLE  = 2'b00,
		BUS_FETCH = 2'b01,
		BUS_ACK   = 2'b10
	} lcdw_bus_t;

endpackage

/* File: rtl/lcdw_seg_mem.sv */
// Segment pattern memory: one word per common line, byte write, two registered reads
`timescale 1ns/1ps
module lcdw_seg_mem (
	input  wire logic                        ref_clk,
	input  wire logic                        rst_n,
	input  wire logic                        wr_en,
	input  wire logic [1:0]                  wr_be,
	input  wire logic [2:0]                  wr_addr,
	input  wire logic [lcdw_pkg::SEG_N-1:0] wr_data,
	input  wire logic [2:0]                  rd_addr_a,
	output logic      [lcdw_pkg::SEG_N-1:0] rd_data_a,
	input  wire logic [2:0]                  rd_addr_b,
	output logic      [lcdw_pkg::SEG_N-1:0] rd_data_b
);

	logic [lcdw_pkg::SEG_N-1:0] mem_q [lcdw_pkg::COM_N];

	// Byte lanes written separately; one process so the array has one writer
	always_ff @(posedge ref_clk) begin
		for (int b = 0; b < 2; b++) begin
			if (wr_en && wr_be[b]) begin
				mem_q[wr_addr][8*b +: 8] <= wr_data[8*b +: 8];
			end
		end
	end

	// Registered reads keep the array off any output path
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data_a <= '0;
			rd_data_b <= '0;
		end else begin
			rd_data_a <= mem_q[rd_addr_a];
			rd_data_b <= mem_q[rd_addr_b];
		end
	end

endmodule // lcdw_seg_mem

/* File: rtl/lcdw_drive_ctrl.sv */
// LCD drive control: Wishbone registers, reset sequencing and common/segment waveforms
//
// The placing of the registers and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ps
module lcdw_drive_ctrl #(
	parameter int unsigned RST_DELAY_NS = 100000,
	parameter int unsigned STARTUP_NS   = 20000
) (
	input  wire logic                                        ref_clk,
	input  wire logic                                        rst_n,
	input  wire logic                                        wb_cyc_i,
	input  wire logic                                        wb_stb_i,
	input  wire logic                                        wb_we_i,
	input  wire logic [7:0]                                  wb_adr_i,
	input  wire logic [3:0]                                  wb_sel_i,
	input  wire logic [31:0]                                 wb_dat_i,
	output logic      [31:0]                                 wb_dat_o,
	output logic                                             wb_ack_o,
	input  wire logic                                        sleep_mode,
	input  wire logic                                        idle_mode,
	input  wire logic                                        mcu_reset,
	input  wire logic                                        wdt_reset,
	output lcdw_pkg::lcdw_pin_t [lcdw_pkg::COM_N-1:0]        com_out,
	output lcdw_pkg::lcdw_pin_t [lcdw_pkg::SEG_N-1:0]        segment_line,
	output logic      [1:0]                                  cbias_source_sel,
	output logic      [1:0]                                  rbias_current_sel,
	output logic                                             bias_kind_select,
	output logic                                             bias_quarter,
	output logic                                             pump_enable
);

	// Float time after MCU reset, rounded up to whole cycles
	localparam int unsigned HOLD_NS  = RST_DELAY_NS + STARTUP_NS;
	localparam int unsigned HOLD_CYC = (HOLD_NS * lcdw_pkg::REF_CLK_MHZ + 999) / 1000;
	localparam int          HOLD_W   = $clog2(HOLD_CYC + 1);
	localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(HOLD_CYC);
	localparam logic [11:0] TICK_LAST = 12'(lcdw_pkg::TICK_CYC - 1);

	lcdw_pkg::lcdw_sys_t sys_in_w;
	lcdw_pkg::lcdw_sys_t sys_m_q;
	lcdw_pkg::lcdw_sys_t sys_s_q;
	lcdw_pkg::lcdw_bus_t bus_q;
	logic [7:0]          main_q;
	logic [7:0]          aux_q;
	logic                ack_q;
	logic [31:0]         dat_q;
	logic [HOLD_W-1:0]   hold_cnt_q;
	logic [11:0]         tick_cnt_q;
	logic [2:0]          slot_q;
	logic [2:0]          phase_q;
	logic                frame_pol_q;
	logic                pump_q;
	logic                float_q;
	logic                lcd_reset_q;
	lcdw_pkg::lcdw_pin_t [lcdw_pkg::COM_N-1:0] com_q;
	lcdw_pkg::lcdw_pin_t [lcdw_pkg::SEG_N-1:0] seg_q;

	// System levels come from another domain: two flops first
	assign sys_in_w = lcdw_pkg::lcdw_sys_t'({sleep_mode, idle_mode, mcu_reset, wdt_reset});

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sys_m_q <= '0;
			sys_s_q <= '0;
		end else begin
			sys_m_q <= sys_in_w;
			sys_s_q <= sys_m_q;
		end
	end

	// Control fields
	wire       en_w      = main_q[lcdw_pkg::MAIN_EN_BIT];
	wire       kind_w    = main_q[lcdw_pkg::MAIN_KIND_BIT];
	wire       type_b_w  = main_q[lcdw_pkg::MAIN_TYPE_BIT];
	wire [1:0] src_w     = main_q[lcdw_pkg::MAIN_SRC_LSB +: 2];
	wire [1:0] duty_w    = aux_q[lcdw_pkg::AUX_DUTY_LSB +: 2];
	// Quarter bias levels for resistor bias only; the bias_quarter pin is not gated by kind
	wire       quarter_w = aux_q[lcdw_pkg::AUX_QUART_BIT] & ~kind_w;

	// Watchdog reset while idle or asleep does not float the pins
	wire excluded_w = sys_s_q.wdt_rst & (sys_s_q.idle | sys_s_q.sleep);
	wire mcu_hold_w = sys_s_q.mcu_rst & ~excluded_w;
	wire float_w    = mcu_hold_w | (hold_cnt_q != '0);
	wire lcd_reset_w = ~en_w | sys_s_q.sleep | float_w;

	// Float counter reloads during MCU reset, counts out after release.
	// Loaded at power-up too, so pins stay floating through start-up.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			hold_cnt_q <= HOLD_LOAD;
		end else if (mcu_hold_w) begin
			hold_cnt_q <= HOLD_LOAD;
		end else if (hold_cnt_q != '0) begin
			hold_cnt_q <= hold_cnt_q - 1'b1;
		end
	end

	// Bus decode
	wire       req_w    = wb_cyc_i & wb_stb_i;
	wire       is_main  = wb_adr_i == lcdw_pkg::ADR_MAIN;
	wire       is_aux   = wb_adr_i == lcdw_pkg::ADR_AUX;
	wire       is_stat  = wb_adr_i == lcdw_pkg::ADR_STAT;
	wire       is_seg   = wb_adr_i[7:5] == lcdw_pkg::ADR_SEG_HI;
	wire       wr_w     = ack_q & req_w & wb_we_i;
	wire       wr_seg_w = wr_w & is_seg;
	wire [lcdw_pkg::SEG_N-1:0] mem_bus_w;
	wire [lcdw_pkg::SEG_N-1:0] seg_word_w;

	// Status word shows the block's own state
	wire [7:0] stat_w;
	assign stat_w[lcdw_pkg::ST_RESET_BIT]      = lcd_reset_q;
	assign stat_w[lcdw_pkg::ST_FLOAT_BIT]      = float_q;
	assign stat_w[lcdw_pkg::ST_PUMP_BIT]       = pump_q;
	assign stat_w[3]                           = 1'b0;
	assign stat_w[lcdw_pkg::ST_PHASE_LSB +: 3] = phase_q;
	assign stat_w[lcdw_pkg::ST_POL_BIT]        = frame_pol_q;

	// Unmapped offsets read zero
	wire [31:0] rd_w = is_main ? {24'h000000, main_q} :
	                   is_aux  ? {24'h000000, aux_q}  :
	                   is_stat ? {24'h000000, stat_w} :
	                   is_seg  ? {16'h0000, mem_bus_w} : 32'h00000000;

	// Three-step cycle: memory read needs one cycle before the answer
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_q <= lcdw_pkg::BUS_IDLE;
			ack_q <= 1'b0;
			dat_q <= '0;
		end else begin
			ack_q <= 1'b0;
			case (bus_q)
				lcdw_pkg::BUS_IDLE: begin
					if (req_w) begin
						bus_q <= lcdw_pkg::BUS_FETCH;
					end
				end
				lcdw_pkg::BUS_FETCH: begin
					bus_q <= lcdw_pkg::BUS_ACK;
					ack_q <= 1'b1;
					dat_q <= rd_w;
				end
				lcdw_pkg::BUS_ACK: begin
					bus_q <= lcdw_pkg::BUS_IDLE;
				end
				default: begin
					bus_q <= lcdw_pkg::BUS_IDLE;
				end
			endcase
		end
	end

	// Writes land on the edge where the master sees ack
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			main_q <= lcdw_pkg::MAIN_RST;
			aux_q  <= lcdw_pkg::AUX_RST;
		end else if (wr_w && wb_sel_i[0]) begin
			if (is_main) begin
				main_q <= wb_dat_i[7:0] & lcdw_pkg::MAIN_MASK;
			end
			if (is_aux) begin
				aux_q <= wb_dat_i[7:0] & lcdw_pkg::AUX_MASK;
			end
		end
	end

	lcdw_seg_mem u_seg_mem (
		.ref_clk   (ref_clk),
		.rst_n     (rst_n),
		.wr_en     (wr_seg_w),
		.wr_be     (wb_sel_i[1:0]),
		.wr_addr   (wb_adr_i[4:2]),
		.wr_data   (wb_dat_i[lcdw_pkg::SEG_N-1:0]),
		.rd_addr_a (wb_adr_i[4:2]),
		.rd_data_a (mem_bus_w),
		.rd_addr_b (phase_q),
		.rd_data_b (seg_word_w)
	);

	// Commons in use for the duty; reserved code behaves as four
	wire [3:0] com_n_w = (duty_w == lcdw_pkg::DUTY_SIXTH)  ? 4'h6 :
	                     (duty_w == lcdw_pkg::DUTY_EIGHTH) ? 4'h8 : 4'h4;
	wire       tick_w    = tick_cnt_q == TICK_LAST;
	wire       div_end_w = tick_w & (slot_q == lcdw_pkg::DIV_LAST);
	// Greater-or-equal so a duty cut mid-frame still wraps
	wire       wrap_w    = {1'b0, phase_q} >= (com_n_w - 4'h1);

	// LCD source tick from the reference clock
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt_q <= '0;
		end else begin
			tick_cnt_q <= tick_w ? 12'h000 : tick_cnt_q + 12'h001;
		end
	end

	// Division slot, common phase and frame polarity
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			slot_q      <= '0;
			phase_q     <= '0;
			frame_pol_q <= 1'b0;
		end else if (lcd_reset_q) begin
			slot_q      <= '0;
			phase_q     <= '0;
			frame_pol_q <= 1'b0;
		end else if (tick_w) begin
			slot_q <= slot_q + 3'h1;
			if (div_end_w) begin
				phase_q <= wrap_w ? 3'h0 : phase_q + 3'h1;
				if (wrap_w) begin
					frame_pol_q <= ~frame_pol_q;
				end
			end
		end
	end

	// First scheme flips inside each division, second once per frame,
	// so the second runs at a fraction of the frequency.
	wire       pol_w   = type_b_w ? frame_pol_q : slot_q[2];
	wire [2:0] top_w   = quarter_w ? lcdw_pkg::LVL_TOP4 : lcdw_pkg::LVL_TOP3;
	wire [2:0] sel_w   = pol_w ? lcdw_pkg::LVL_VSS : top_w;
	wire [2:0] unsel_w = pol_w ? top_w - 3'h1 : lcdw_pkg::LVL_ONE;
	wire [2:0] on_w    = pol_w ? top_w : lcdw_pkg::LVL_VSS;
	wire [2:0] off_w   = (quarter_w || !pol_w) ? lcdw_pkg::LVL_TWO : lcdw_pkg::LVL_ONE;

	// Pump runs only for capacitor bias fed from the supply pin
	wire pump_d = en_w & kind_w & (src_w == lcdw_pkg::SRC_EXT_PIN) & ~lcd_reset_w;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pump_q      <= 1'b0;
			float_q     <= 1'b1;
			lcd_reset_q <= 1'b1;
		end else begin
			pump_q      <= pump_d;
			float_q     <= float_w;
			lcd_reset_q <= lcd_reset_w;
		end
	end

	// Common lines; outside LCD reset unused ones float so they may serve as plain I/O
	for (genvar i = 0; i < lcdw_pkg::COM_N; i++) begin : g_com
		lcdw_pkg::lcdw_pin_t com_d;
		assign com_d = float_w     ? '{1'b0, lcdw_pkg::LVL_VSS} :
		               lcd_reset_w ? '{1'b1, lcdw_pkg::LVL_VSS} :
		               (4'(i) >= com_n_w) ? '{1'b0, lcdw_pkg::LVL_VSS} :
		               (phase_q == 3'(i)) ? '{1'b1, sel_w} : '{1'b1, unsel_w};
		always_ff @(posedge ref_clk or negedge rst_n) begin
			if (!rst_n) begin
				com_q[i] <= '0;
			end else begin
				com_q[i] <= com_d;
			end
		end
	end

	// Segment lines from the pattern word of the active common.
	// The pattern lags the phase by one cycle at each division edge.
	for (genvar i = 0; i < lcdw_pkg::SEG_N; i++) begin : g_seg
		lcdw_pkg::lcdw_pin_t seg_d;
		assign seg_d = float_w     ? '{1'b0, lcdw_pkg::LVL_VSS} :
		               lcd_reset_w ? '{1'b1, lcdw_pkg::LVL_VSS} :
		               seg_word_w[i] ? '{1'b1, on_w} : '{1'b1, off_w};
		always_ff @(posedge ref_clk or negedge rst_n) begin
			if (!rst_n) begin
				seg_q[i] <= '0;
			end else begin
				seg_q[i] <= seg_d;
			end
		end
	end

	// Outputs straight from flops
	assign wb_dat_o          = dat_q;
	assign wb_ack_o          = ack_q;
	assign com_out           = com_q;
	assign segment_line      = seg_q;
	assign cbias_source_sel  = main_q[lcdw_pkg::MAIN_SRC_LSB +: 2];
	assign rbias_current_sel = main_q[lcdw_pkg::MAIN_IS_LSB +: 2];
	assign bias_kind_select  = main_q[lcdw_pkg::MAIN_KIND_BIT];
	assign bias_quarter      = aux_q[lcdw_pkg::AUX_QUART_BIT];
	assign pump_enable       = pump_q;

	// Checks
	reset_clears_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(lcd_reset_q && !tick_w) |=> (phase_q == 3'h0 && slot_q == 3'h0))
		else $error("phase not cleared in LCD reset");

	disabled_low_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(!float_w && !en_w) |=> (com_q[0].oe && com_q[0].level == 3'h0
			&& seg_q[0].oe && seg_q[0].level == 3'h0))
		else $error("disabled driver not low");

	sleep_low_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(sys_s_q.sleep && en_w && !float_w) |=> (seg_q[15].oe && seg_q[15].level == 3'h0))
		else $error("sleep did not drive low");

	mcu_float_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		mcu_hold_w |=> (!com_q[0].oe && !seg_q[0].oe && !pump_q) [*2])
		else $error("pins not floating in MCU reset");

	float_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$fell(mcu_hold_w) |-> (hold_cnt_q == HOLD_LOAD) ##1 float_w)
		else $error("float time not loaded");

	wdt_exempt_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(sys_s_q.mcu_rst && excluded_w && hold_cnt_q == '0) |=> !float_q)
		else $error("watchdog reset floated pins");

	phase_wrap_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(div_end_w && !lcd_reset_q) |=> ({1'b0, phase_q} < com_n_w))
		else $error("phase beyond duty");

	pump_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		pump_q |-> ($past(kind_w) && $past(src_w) == 2'h0 && !$past(lcd_reset_w)))
		else $error("pump enabled outside pin-fed capacitor bias");

	type_a_flip_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(!type_b_w && tick_w && slot_q == 3'h3 && !lcd_reset_w && !quarter_w
			&& $stable(main_q) && phase_q == 3'h0)
		|=> ##1 (com_q[0].level == 3'h0))
		else $error("first scheme did not flip mid-division");

	unused_com_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(!float_w && !lcd_reset_w && duty_w == lcdw_pkg::DUTY_QUARTER)
		|=> (!com_q[4].oe && !com_q[7].oe && com_q[3].oe))
		else $error("unused commons not released");

	sleep_pump_off_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		sys_s_q.sleep |=> !pump_q)
		else $error("pump running in sleep");

	typeb_pol_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(type_b_w && !div_end_w && !lcd_reset_q) |=> $stable(frame_pol_q))
		else $error("second scheme flipped inside a frame");

	com_range_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(!float_w && !lcd_reset_w && !quarter_w) |=> (com_q[0].level <= 3'h3))
		else $error("common level above top");

endmodule // lcdw_drive_ctrl

/* File: testbench/lcdw_glass_model.sv */
// Passive segment glass: reports how the panel sees the common and segment pins
`timescale 1ns/1ps
module lcdw_glass_model (
	input  wire lcdw_pkg::lcdw_pin_t [lcdw_pkg::COM_N-1:0] com,
	input  wire lcdw_pkg::lcdw_pin_t [lcdw_pkg::SEG_N-1:0] seg,
	output logic                                           any_float,
	output logic                                           all_low
);
	// Only the four commons used at every duty are judged; higher ones may float by duty
	always_comb begin
		any_float = 1'b0;
		all_low   = 1'b1;
		for (int k = 0; k < 4; k++) begin
			any_float = any_float | !com[k].oe;
			all_low   = all_low & com[k].oe & (com[k].level == 3'h0);
		end
		for (int k = 0; k < lcdw_pkg::SEG_N; k++) begin
			any_float = any_float | !seg[k].oe;
			all_low   = all_low & seg[k].oe & (seg[k].level == 3'h0);
		end
	end
endmodule // lcdw_glass_model

/* File: testbench/lcdw_drive_ctrl_test.sv */
// Self-checking bench of the LCD drive control block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_errors++; \
	$display("BAD %s exp %0h got %0h", nm, e, g); end end
module lcdw_drive_ctrl_test;
	logic                                   ref_clk = 1'b0;
	logic                                   rst_n = 1'b0;
	logic                                   wb_cyc = 1'b0;
	logic                                   wb_stb = 1'b0;
	logic                                   wb_we = 1'b0;
	logic [7:0]                             wb_adr = 8'h00;
	logic [3:0]                             wb_sel = 4'h0;
	logic [31:0]                            wb_dat = 32'h0;
	logic [31:0]                            wb_dat_o;
	logic                                   wb_ack_o;
	logic                                   sleep_m = 1'b0;
	logic                                   idle_m = 1'b0;
	logic                                   mcu_rst = 1'b0;
	logic                                   wdt_rst = 1'b0;
	lcdw_pkg::lcdw_pin_t [lcdw_pkg::COM_N-1:0] com_out;
	lcdw_pkg::lcdw_pin_t [lcdw_pkg::SEG_N-1:0] seg_out;
	logic [1:0]                             src_sel;
	logic [1:0]                             cur_sel;
	logic                                   kind;
	logic                                   quarter;
	logic                                   pump;
	logic                                   any_float;
	logic                                   all_low;
	logic [31:0]                            q;
	logic [7:0]                             m;
	int                                     n_errors = 0;
	int                                     compares = 0;
	int                                     n;

	// 125 MHz reference clock
	always #4 ref_clk = ~ref_clk;

	// Short reset delay and start-up so the float hold is ten cycles
	lcdw_drive_ctrl #(.RST_DELAY_NS(40), .STARTUP_NS(40)) u_dut (
		.ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sleep_mode(sleep_m), .idle_mode(idle_m),
		.mcu_reset(mcu_rst), .wdt_reset(wdt_rst), .com_out(com_out), .segment_line(seg_out),
		.cbias_source_sel(src_sel), .rbias_current_sel(cur_sel), .bias_kind_select(kind),
		.bias_quarter(quarter), .pump_enable(pump));

	lcdw_glass_model u_glass (.com(com_out), .seg(seg_out), .any_float(any_float),
		.all_low(all_low));

	task automatic end_of_test();
		$display("checks %0d errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Classic single cycle: hold everything until ack is sampled, then release
	// Only the watchdog ends a wait for ack; ack must be gone one cycle later
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		wb_cyc <= 1'b1; wb_stb <= 1'b1; wb_we <= we; wb_adr <= a; wb_dat <= d; wb_sel <= 4'hf;
		do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc <= 1'b0; wb_stb <= 1'b0; wb_we <= 1'b0;
		@(posedge ref_clk);
		`CHK("wb_ack", 1'b0, wb_ack_o)
	endtask

	// Bounded wait for one common to reach a given level, then three more cycles
	task automatic wait_com(input int c, input logic [2:0] lv, input int lim);
		n = 0;
		while (com_out[c].level !== lv && n < lim) begin @(posedge ref_clk); n++; end
		repeat (3) @(posedge ref_clk);
	endtask

	task automatic t_reset();
		n = 0;
		while (com_out[0].oe !== 1'b1 && n < 60) begin @(posedge ref_clk); n++; end
		`CHK("hold_len", 1'b1, n >= 10 && n <= 16)
		repeat (2) @(posedge ref_clk);
		`CHK("off_low", 1'b1, all_low)
		wb(0, 8'h00, 0); `CHK("ctrl_rst", 32'h0, q)
		wb(0, 8'h04, 0); `CHK("duty_rst", 32'h0, q)
		wb(0, 8'hfc, 0); `CHK("unmapped", 32'h0, q)
		wb(0, 8'h08, 0); `CHK("st_rst", 1'b1, q[lcdw_pkg::ST_RESET_BIT])
	endtask

	// Every source and current code; pump only for capacitor bias from the pin
	task automatic t_bias();
		wb(1, 8'h00, 32'hff); wb(0, 8'h00, 0); `CHK("ctrl_rb", 32'hf7, q)
		for (int s = 0; s < 4; s++) begin
			wb(1, 8'h00, 32'h41 | (s << 4) | (s << 1));
			repeat (4) @(posedge ref_clk);
			`CHK("src", s[1:0], src_sel)
			`CHK("cur", s[1:0], cur_sel)
			`CHK("kind", 1'b1, kind)
			`CHK("pump", s == 0, pump)
		end
		wb(1, 8'h00, 32'h01); repeat (4) @(posedge ref_clk);
		`CHK("pump_r", 1'b0, pump)
	endtask

	// Duty code sets how many commons are driven; code 3 acts as four
	task automatic t_duty();
		for (int d = 0; d < 4; d++) begin
			wb(1, 8'h04, (d << 1) | (d & 1)); repeat (4) @(posedge ref_clk);
			for (int k = 0; k < 8; k++) m[k] = com_out[k].oe;
			`CHK("coms", d == 1 ? 8'h3f : d == 2 ? 8'hff : 8'h0f, m)
			`CHK("quarter", d[0], quarter)
		end
		wb(1, 8'h04, 0);
	endtask

	// Pixel of com0/seg0 sees +3 then -3 steps within one division
	task automatic t_wave();
		// Pattern memory has no reset: clear the words the phases will read
		for (int k = 1; k < 8; k++) wb(1, 8'h40 + 8'(4 * k), 0);
		wb(1, 8'h00, 0); wb(1, 8'h40, 1); wb(1, 8'h00, 1);
		repeat (3) @(posedge ref_clk);
		`CHK("c0_a", 3'h3, com_out[0].level)
		`CHK("c1_a", 3'h1, com_out[1].level)
		`CHK("s0_a", 3'h0, seg_out[0].level)
		`CHK("s1_a", 3'h2, seg_out[1].level)
		wait_com(0, 3'h0, 16000);
		`CHK("c1_b", 3'h2, com_out[1].level)
		`CHK("s0_b", 3'h3, seg_out[0].level)
		`CHK("s1_b", 3'h1, seg_out[1].level)
		wait_com(1, 3'h3, 16000);
		`CHK("c0_c", 3'h1, com_out[0].level)
		`CHK("s0_c", 3'h2, seg_out[0].level)
		wb(0, 8'h08, 0); `CHK("phase", 3'h1, q[6:4])
	endtask

	// Second scheme keeps polarity across the half division
	task automatic t_typeb();
		wb(1, 8'h00, 0); wb(1, 8'h00, 32'h81);
		repeat (4 * lcdw_pkg::TICK_CYC + 200) @(posedge ref_clk);
		`CHK("typeb", 3'h3, com_out[0].level)
		wb(1, 8'h00, 0); wb(1, 8'h00, 1);
	endtask

	task automatic t_sleep();
		sleep_m <= 1'b1; repeat (6) @(posedge ref_clk);
		`CHK("sl_low", 1'b1, all_low)
		wb(0, 8'h08, 0); `CHK("sl_rst", 1'b1, q[lcdw_pkg::ST_RESET_BIT])
		sleep_m <= 1'b0; repeat (6) @(posedge ref_clk);
		`CHK("sl_back", 1'b0, all_low)
	endtask

	// MCU reset floats pins even during sleep, then holds the float
	task automatic t_mcu();
		sleep_m <= 1'b1; mcu_rst <= 1'b1; repeat (6) @(posedge ref_clk);
		`CHK("fl", 1'b1, any_float)
		wb(0, 8'h08, 0); `CHK("st_fl", 1'b1, q[lcdw_pkg::ST_FLOAT_BIT])
		sleep_m <= 1'b0; mcu_rst <= 1'b0; @(posedge ref_clk);
		n = 0;
		while (com_out[0].oe !== 1'b1 && n < 60) begin @(posedge ref_clk); n++; end
		`CHK("fl_len", 1'b1, n >= 10 && n <= 16)
	endtask

	// Watchdog time-out while idle must not float the pins
	task automatic t_wdt();
		idle_m <= 1'b1; wdt_rst <= 1'b1; mcu_rst <= 1'b1; repeat (8) @(posedge ref_clk);
		`CHK("wdt", 1'b0, any_float)
		idle_m <= 1'b0; wdt_rst <= 1'b0; mcu_rst <= 1'b0;
	endtask

	// Main sequence
	initial begin
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'b1;
		t_reset();
		t_bias();
		t_duty();
		t_wave();
		t_typeb();
		t_sleep();
		t_mcu();
		t_wdt();
		end_of_test();
	end

	// Hang guard, well beyond the roughly 50k cycles the sequence needs
	initial begin
		repeat (100000) @(posedge ref_clk);
		n_errors++;
		end_of_test();
	end
endmodule // lcdw_drive_ctrl_test
